/* rtl/tec_timer.sv */
// tec_timer: 8-bit timer/event counter with AXI4-Lite registers.
// assumes one system clock; event pin is asynchronous and synchronised.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module tec_timer
   import tec_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic warmReset,
   input wire logic eventPin,
   output logic divOut,
   output logic wakeUp,
   output logic irqReq,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ======================================================
   // declarations
   tec_ctrl_s ctrl_r;
   logic [7:0] count_r;
   logic [7:0] preload_r;
   logic ovfFlag_r;
   logic irqEn_r;
   logic divOut_r;
   logic wakeUp_r;
   logic irqReq_r;
   logic awHeld_r;
   logic wHeld_r;
   logic [7:0] awIdx_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;
   logic bValid_r;
   logic [1:0] bResp_r;
   logic rValid_r;
   logic [31:0] rData_r;
   logic [1:0] rResp_r;
   logic awReady_r;
   logic wReady_r;
   logic arReady_r;
   logic awHeld_nxt;
   logic wHeld_nxt;
   logic bValid_nxt;
   logic rValid_nxt;
   logic pinRise;
   logic pinFall;
   logic fintTick;
   tec_req_s req;
   logic doWrite;
   logic doRead;
   logic [7:0] rdIdx;
   logic [7:0] wrByte;
   logic countStep;
   logic overflow;
   logic pulseDone;
   logic activeEdge;
   logic pulseStart;
   logic returnEdge;

   // pulse measurement phase
   typedef enum logic [2:0] {
      PW_ARM = 3'b001,
      PW_COUNT = 3'b010,
      PW_HELD = 3'b100
   } tec_pw_e;
   tec_pw_e pw_r;
   tec_pw_e pw_nxt;

   // word index from a byte address
   function automatic logic [7:0] wordIdx(input logic [31:0] addr);
      return addr[9:2];
   endfunction : wordIdx

   function automatic logic mapped(input logic [7:0] idx);
      return (idx == IDX_COUNT) || (idx == IDX_CTRL) ||
         (idx == IDX_INTERRUPT_CONTROL_REGISTER);
   endfunction : mapped

   // ======================================================
   // submodules
   tec_pin_sync u_sync (
      .clock(clock),
      .rstn(rstn),
      .pinAsync(eventPin),
      .level(),
      .rise(pinRise),
      .fall(pinFall)
   );

   tec_prescaler #(.WIDTH(8)) u_psc (
      .clock(clock),
      .rstn(rstn),
      .sel(ctrl_r.psc),
      .tick(fintTick)
   );

   // ======================================================
   // AXI4-Lite write side: hold address and data until both present
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awIdx_r <= 8'h00;
         wData_r <= 32'h0000_0000;
         wStrb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r <= 1'b1;
            awIdx_r <= wordIdx(s_axi_awaddr);
         end else if (doWrite) begin
            awHeld_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end else if (doWrite) begin
            wHeld_r <= 1'b0;
         end
      end
   end

   assign doWrite = awHeld_r & wHeld_r & ~bValid_r;
   assign awHeld_nxt = (s_axi_awvalid & s_axi_awready) |
      (awHeld_r & ~doWrite);
   assign wHeld_nxt = (s_axi_wvalid & s_axi_wready) |
      (wHeld_r & ~doWrite);
   assign wrByte = wData_r[7:0];

   // write response, one cycle after both halves are held
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bValid_r <= 1'b0;
         bResp_r <= RESP_OKAY;
      end else begin
         if (doWrite) begin
            bValid_r <= 1'b1;
            bResp_r <= mapped(awIdx_r) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bValid_r <= 1'b0;
         end
      end
   end

   // ======================================================
   // AXI4-Lite read side: accept and answer in the next cycle
   assign doRead = s_axi_arvalid & ~rValid_r;
   assign rdIdx = wordIdx(s_axi_araddr);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rValid_r <= 1'b0;
         rData_r <= 32'h0000_0000;
         rResp_r <= RESP_OKAY;
      end else begin
         if (doRead) begin
            rValid_r <= 1'b1;
            rResp_r <= mapped(rdIdx) ? RESP_OKAY : RESP_SLVERR;
            unique case (rdIdx)
               IDX_COUNT: rData_r <= {24'h000000, count_r};
               IDX_CTRL: rData_r <= {24'h000000, ctrl_r};
               IDX_INTERRUPT_CONTROL_REGISTER: rData_r <= {24'h000000, 2'h0, ovfFlag_r,
                  2'h0, irqEn_r, 2'h0};
               default: rData_r <= 32'h0000_0000;
            endcase
         end else if (s_axi_rready) begin
            rValid_r <= 1'b0;
         end
      end
   end

   // ======================================================
   // ready flops: same value as ~held & ~valid, computed one edge early
   // so every bus output leaves a flop; costs a few next-state terms
   assign bValid_nxt = doWrite | (bValid_r & ~s_axi_bready);
   assign rValid_nxt = doRead | (rValid_r & ~s_axi_rready);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         awReady_r <= 1'b1;
         wReady_r <= 1'b1;
         arReady_r <= 1'b1;
      end else begin
         awReady_r <= ~awHeld_nxt & ~bValid_nxt;
         wReady_r <= ~wHeld_nxt & ~bValid_nxt;
         arReady_r <= ~rValid_nxt;
      end
   end

   assign s_axi_awready = awReady_r;
   assign s_axi_wready = wReady_r;
   assign s_axi_arready = arReady_r;

   // ======================================================
   // request bundle toward the counter core
   always_comb begin
      req = '0;
      req.data = wrByte;
      req.countWr = doWrite & wStrb_r[0] & (awIdx_r == IDX_COUNT);
      req.ctrlWr = doWrite & wStrb_r[0] & (awIdx_r == IDX_CTRL);
      req.countRd = doRead & (rdIdx == IDX_COUNT);
   end

   // ======================================================
   // count source select and overflow
   assign activeEdge = ctrl_r.edgeFall ? pinFall : pinRise;
   // pulse mode reads the edge bit the other way: set opens on a rise
   assign pulseStart = ctrl_r.edgeFall ? pinRise : pinFall;
   assign returnEdge = ctrl_r.edgeFall ? pinFall : pinRise;

   always_comb begin
      countStep = 1'b0;
      // a warm reset freezes counting, so no overflow side effects either
      if (ctrl_r.run && !req.countRd && !warmReset) begin
         unique case (ctrl_r.mode)
            MODE_EVENT: countStep = activeEdge;
            MODE_TIMER: countStep = fintTick;
            MODE_PULSE: countStep = fintTick && pw_r == PW_COUNT;
            MODE_NONE: countStep = 1'b0;
         endcase
      end
   end

   assign overflow = countStep & (count_r == COUNT_MAX);
   assign pulseDone = ctrl_r.run & (ctrl_r.mode == MODE_PULSE) &
      (pw_r == PW_COUNT) & returnEdge;

   // ======================================================
   // pulse measurement sequencer
   always_comb begin
      pw_nxt = pw_r;
      unique case (pw_r)
         PW_ARM: begin
            // edge, not level, opens the window
            if (ctrl_r.run && ctrl_r.mode == MODE_PULSE && pulseStart) begin
               pw_nxt = PW_COUNT;
            end
         end
         PW_COUNT: begin
            if (pulseDone) begin
               pw_nxt = PW_HELD;
            end else if (!ctrl_r.run || ctrl_r.mode != MODE_PULSE) begin
               pw_nxt = PW_ARM;
            end
         end
         PW_HELD: begin
            // result stays until software sets run again
            if (req.ctrlWr && req.data[RUN_BIT]) begin
               pw_nxt = PW_ARM;
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pw_r <= PW_ARM;
      end else if (!warmReset) begin
         pw_r <= pw_nxt;
      end
   end

   // ======================================================
   // control register; warm reset leaves it untouched
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= tec_ctrl_s'(CTRL_RESET);
      end else if (!warmReset) begin
         if (req.ctrlWr) begin
            ctrl_r <= tec_ctrl_s'(req.data & CTRL_WMASK);
         end else if (pulseDone) begin
            ctrl_r.run <= 1'b0;
         end
      end
   end

   // ======================================================
   // preload and counter
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         preload_r <= COUNT_RESET;
      end else if (!warmReset && req.countWr) begin
         preload_r <= req.data;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         count_r <= COUNT_RESET;
      end else if (!warmReset) begin
         if (req.countWr && !ctrl_r.run) begin
            count_r <= req.data;
         end else if (overflow) begin
            count_r <= preload_r;
         end else if (countStep) begin
            count_r <= count_r + 8'h01;
         end
      end
   end

   // ======================================================
   // interrupt control bits: overflow set beats software clear
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ovfFlag_r <= INTERRUPT_CONTROL_REGISTER_RESET[OVF_BIT];
         irqEn_r <= INTERRUPT_CONTROL_REGISTER_RESET[IEN_BIT];
      end else if (!warmReset) begin
         if (doWrite && wStrb_r[0] && awIdx_r == IDX_INTERRUPT_CONTROL_REGISTER) begin
            ovfFlag_r <= wrByte[OVF_BIT] | overflow;
            irqEn_r <= wrByte[IEN_BIT];
         end else if (overflow) begin
            ovfFlag_r <= 1'b1;
         end
      end
   end

   // ======================================================
   // registered outputs
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         divOut_r <= 1'b0;
         wakeUp_r <= 1'b0;
         irqReq_r <= 1'b0;
      end else begin
         if (overflow) begin
            divOut_r <= ~divOut_r;
         end
         wakeUp_r <= overflow;
         irqReq_r <= ovfFlag_r & irqEn_r;
      end
   end

   assign divOut = divOut_r;
   assign wakeUp = wakeUp_r;
   assign irqReq = irqReq_r;
   assign s_axi_bvalid = bValid_r;
   assign s_axi_bresp = bResp_r;
   assign s_axi_rvalid = rValid_r;
   assign s_axi_rdata = rData_r;
   assign s_axi_rresp = rResp_r;

endmodule : tec_timer

/* common/tec_pkg.sv */
// tec_pkg: constants and carrier types for the 8-bit timer/event counter.
// assumes an AXI4-Lite slave with 32-bit data; offsets are word indices.
package tec_pkg;
   // ======================================================
   // register map (printed index, byte address is 4x)
   localparam logic [7:0] IDX_COUNT = 8'h0D;
   localparam logic [7:0] IDX_CTRL = 8'h0E;
   localparam logic [7:0] IDX_INTERRUPT_CONTROL_REGISTER = 8'h0B;
   localparam logic [7:0] CTRL_RESET = 8'h08;
   localparam logic [7:0] INTERRUPT_CONTROL_REGISTER_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   // ======================================================
   // field positions
   localparam int PSC_LSB = 0;
   localparam int EDGE_BIT = 3;
   localparam int RUN_BIT = 4;
   localparam int MODE_LSB = 6;
   localparam int IEN_BIT = 2;
   localparam int OVF_BIT = 5;
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [7:0] CTRL_WMASK = 8'hDF;
   localparam logic [7:0] INTERRUPT_CONTROL_REGISTER_WMASK = 8'h24;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      MODE_NONE = 2'h0,
      MODE_EVENT = 2'h1,
      MODE_TIMER = 2'h2,
      MODE_PULSE = 2'h3
   } tec_mode_e;

   // control register layout
   typedef struct packed {
      tec_mode_e mode;
      logic unused5;
      logic run;
      logic edgeFall;
      logic [2:0] psc;
   } tec_ctrl_s;

   // software access toward the counter core
   typedef struct packed {
      logic countWr;
      logic countRd;
      logic ctrlWr;
      logic [7:0] data;
   } tec_req_s;
endpackage : tec_pkg

/* rtl/tec_prescaler.sv */
// tec_prescaler: divides the system clock by 2..256, one-cycle tick out.
// assumes the select comes from a register on the same clock.
`timescale 1ns/1ps
module tec_prescaler
   import tec_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [2:0] sel,
   output logic tick
);
   logic [WIDTH-1:0] div_r;

   // ======================================================
   // free running divider; a select change may give one odd period
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end

   // tick when the low sel+1 bits are all ones: /2 .. /256
   always_comb begin
      logic [WIDTH-1:0] m;
      m = '0;
      m = (WIDTH'(2) << sel) - 1'b1;
      tick = ((div_r & m) == m);
   end
endmodule : tec_prescaler

/* rtl/tec_pin_sync.sv */
// tec_pin_sync: two-flop synchroniser plus edge detect for the event pin.
// assumes the pin is asynchronous to clock.
`timescale 1ns/1ps
module tec_pin_sync (
   input wire logic clock,
   input wire logic rstn,
   input wire logic pinAsync,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_r;
   logic sync_r;
   logic last_r;

   // ======================================================
   // meta_r is read only by sync_r
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         last_r <= 1'b0;
      end else begin
         meta_r <= pinAsync;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   assign level = sync_r;
   assign rise = sync_r & ~last_r;
   assign fall = ~sync_r & last_r;
endmodule : tec_pin_sync

/* tb/tec_sva.sv */
// tec_sva: port-level checks for the timer/event counter.
// assumes bind onto tec_timer; one clock, async active-low reset.
`timescale 1ns/1ps
module tec_sva (
   input wire logic clock,
   input wire logic rstn,
   input wire logic warmReset,
   input wire logic divOut,
   input wire logic wakeUp,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // ======================================================
   // bus steps
   sequence s_wrTaken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rdTaken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // three held cycles, so an overflow already in flight has landed
   sequence s_warmHeld;
      warmReset [*3];
   endsequence
   property p_wrResp;
      s_wrTaken |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_wrResp: assert property (p_wrResp) else $error("no bvalid");
   property p_wrHold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_wrHold: assert property (p_wrHold) else $error("bresp moved");
   property p_rdResp;
      s_rdTaken |=> s_axi_rvalid;
   endproperty
   a_rdResp: assert property (p_rdResp) else $error("no rvalid");
   property p_rdHold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rdHold: assert property (p_rdHold) else $error("rdata moved");
   property p_rdUpper;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_rdUpper: assert property (p_rdUpper) else $error("upper bits");
   // ======================================================
   // overflow side effects
   property p_divWake;
      $changed(divOut) |-> ##[0:1] wakeUp;
   endproperty
   a_divWake: assert property (p_divWake) else $error("toggle no wake");
   property p_wakePulse;
      wakeUp |=> !wakeUp;
   endproperty
   a_wakePulse: assert property (p_wakePulse) else $error("long wake");
   property p_warmFreeze;
      s_warmHeld |-> !wakeUp && $stable(divOut);
   endproperty
   a_warmFreeze: assert property (p_warmFreeze) else $error("warm run");
endmodule : tec_sva

bind tec_timer tec_sva u_sva (.clock, .rstn, .warmReset, .divOut, .wakeUp,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

/* tb/tec_pin_model.sv */
// tec_pin_model: drives the external event/pulse pin.
// assumes the bench calls its tasks; the pin is asynchronous to clock.
`timescale 1ns/1ps
module tec_pin_model (
   input wire logic clock,
   output logic pin
);
   // ======================================================
   // pin driver
   // changes land on an edge by non-blocking assignment; the
   // synchroniser first takes them at the following edge
   initial pin = 1'b0;
   task automatic setLvl(input logic v);
      @(posedge clock);
      pin <= v;
   endtask : setLvl
   // one high phase then one low phase, lengths in clocks
   task automatic pulse(input int hi, input int lo);
      setLvl(1'b1);
      repeat (hi) @(posedge clock);
      setLvl(1'b0);
      repeat (lo) @(posedge clock);
   endtask : pulse
endmodule : tec_pin_model

/* tb/tb_tec_timer.sv */
// tb_tec_timer: self-checking bench for the 8-bit timer/event counter.
// assumes package, design, pin model and checker are compiled first.
`timescale 1ns/1ps
module tb_tec_timer;
   import tec_pkg::*;
   typedef struct {
      logic [7:0] idx;
      logic [7:0] wd;
      logic [7:0] rd;
      logic [1:0] rsp;
      logic irq;
   } tec_row_s;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic warmReset = 1'b0;
   logic eventPin, divOut, wakeUp, irqReq;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [7:0] rd, hold;
   int num_errors = 0;
   int checked = 0;
   int n;
   // index, write, read back, response, irq level
   tec_row_s rows[7] = '{
      '{IDX_COUNT, 8'h5A, 8'h5A, RESP_OKAY, 1'b0},
      '{IDX_CTRL, 8'hFF, 8'hDF, RESP_OKAY, 1'b0},
      '{IDX_CTRL, 8'h08, 8'h08, RESP_OKAY, 1'b0},
      '{IDX_INTERRUPT_CONTROL_REGISTER, 8'h24, 8'h24, RESP_OKAY, 1'b1},
      '{IDX_INTERRUPT_CONTROL_REGISTER, 8'h20, 8'h20, RESP_OKAY, 1'b0},
      '{IDX_INTERRUPT_CONTROL_REGISTER, 8'h00, 8'h00, RESP_OKAY, 1'b0},
      '{8'h01, 8'h55, 8'h00, RESP_SLVERR, 1'b0}};

   tec_timer dut (.clock, .rstn, .warmReset, .eventPin, .divOut, .wakeUp,
      .irqReq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   tec_pin_model pin (.clock, .pin(eventPin));

   initial forever #2 clock = ~clock;
   // ======================================================
   // helpers
   task automatic complete_run();
      $display("checked=%0d num_errors=%0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // ready is looked at on the falling edge, where it has settled
   task automatic axW(input logic [7:0] idx, input logic [7:0] d);
      logic aT, wT, bT;
      @(posedge clock);
      s_axi_awaddr <= {22'h0, idx, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge clock);
         aT = s_axi_awvalid & s_axi_awready;
         wT = s_axi_wvalid & s_axi_wready;
         bT = s_axi_bvalid;
         rsp = s_axi_bresp;
         @(posedge clock);
         if (aT) s_axi_awvalid <= 1'b0;
         if (wT) s_axi_wvalid <= 1'b0;
      end while (!bT);
      s_axi_bready <= 1'b0;
   endtask : axW
   task automatic axR(input logic [7:0] idx);
      logic aT, rT;
      @(posedge clock);
      s_axi_araddr <= {22'h0, idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge clock);
         aT = s_axi_arvalid & s_axi_arready;
         rT = s_axi_rvalid;
         rd = s_axi_rdata[7:0];
         rsp = s_axi_rresp;
         @(posedge clock);
         if (aT) s_axi_arvalid <= 1'b0;
      end while (!rT);
      s_axi_rready <= 1'b0;
   endtask : axR
   task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
      axR(idx);
      chk(rd, exp);
   endtask : rdChk
   // clocks until the divided output next changes level
   task automatic edgeWait();
      logic d;
      n = 0;
      d = divOut;
      do begin
         @(negedge clock);
         n++;
      end while (divOut === d && n < 4000);
      chk(wakeUp, 1'b1);
   endtask : edgeWait

   // watchdog: the whole run needs well under this
   initial begin
      repeat (30000) @(posedge clock);
      num_errors++;
      complete_run();
   end
   // ======================================================
   // main sequence
   initial begin
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      rdChk(IDX_CTRL, CTRL_RESET);
      rdChk(IDX_COUNT, COUNT_RESET);
      foreach (rows[i]) begin
         axW(rows[i].idx, rows[i].wd);
         chk(rsp, rows[i].rsp);
         axR(rows[i].idx);
         chk(rd, rows[i].rd);
         chk(rsp, rows[i].rsp);
         repeat (3) @(posedge clock);
         chk(irqReq, rows[i].irq);
      end
      // timer mode from 0xFC at /2, /4 and /8: four ticks to each overflow
      axW(IDX_COUNT, 8'hFC);
      axW(IDX_CTRL, 8'h90);
      repeat (20) @(posedge clock);
      rdChk(IDX_INTERRUPT_CONTROL_REGISTER, 8'h20);
      chk(irqReq, 1'b0);
      rdChk(IDX_CTRL, 8'h90);
      for (int c = 0; c < 3; c++) begin
         axW(IDX_CTRL, 8'h90 | c[7:0]);
         repeat (3) edgeWait();
         chk(n, 4 << (c + 1));
      end
      // new preload while running waits for the next reload
      edgeWait();
      axW(IDX_COUNT, 8'h10);
      axR(IDX_COUNT);
      chk(rd[7:2], 6'h3F);
      repeat (2) edgeWait();
      chk(n, 1920);
      @(posedge clock);
      warmReset <= 1'b1;
      axW(IDX_CTRL, 8'h00);
      repeat (40) @(posedge clock);
      warmReset <= 1'b0;
      rdChk(IDX_CTRL, 8'h92);
      // event mode, rising then falling edges
      axW(IDX_CTRL, 8'h00);
      axW(IDX_COUNT, 8'hFD);
      axW(IDX_INTERRUPT_CONTROL_REGISTER, 8'h00);
      axW(IDX_CTRL, 8'h50);
      repeat (2) pin.pulse(3, 3);
      rdChk(IDX_COUNT, 8'hFF);
      pin.pulse(3, 3);
      rdChk(IDX_COUNT, 8'hFD);
      rdChk(IDX_INTERRUPT_CONTROL_REGISTER, 8'h20);
      axW(IDX_CTRL, 8'h58);
      pin.setLvl(1'b1);
      repeat (6) @(posedge clock);
      rdChk(IDX_COUNT, 8'hFD);
      pin.setLvl(1'b0);
      repeat (6) @(posedge clock);
      rdChk(IDX_COUNT, 8'hFE);
      // pulse width: armed on a high level, starts only on an edge
      axW(IDX_CTRL, 8'h00);
      axW(IDX_COUNT, 8'h00);
      pin.setLvl(1'b1);
      axW(IDX_CTRL, 8'hD8);
      repeat (20) @(posedge clock);
      rdChk(IDX_COUNT, 8'h00);
      pin.setLvl(1'b0);
      repeat (6) @(posedge clock);
      pin.pulse(40, 10);
      axR(IDX_COUNT);
      hold = rd;
      chk(hold >= 8'h13 && hold <= 8'h16, 1'b1);
      rdChk(IDX_CTRL, 8'hC8);
      pin.pulse(10, 10);
      rdChk(IDX_COUNT, hold);
      axW(IDX_CTRL, 8'hD8);
      pin.pulse(20, 10);
      axR(IDX_COUNT);
      chk(rd > hold, 1'b1);
      // pulse mode overflow reloads from preload and raises the flag
      axW(IDX_CTRL, 8'h00);
      axW(IDX_COUNT, 8'hFE);
      axW(IDX_INTERRUPT_CONTROL_REGISTER, 8'h00);
      axW(IDX_CTRL, 8'hD8);
      pin.pulse(20, 10);
      axR(IDX_COUNT);
      chk(rd[7:1], 7'h7F);
      rdChk(IDX_INTERRUPT_CONTROL_REGISTER, 8'h20);
      // second cold reset in mid-run
      rstn <= 1'b0;
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      rdChk(IDX_CTRL, CTRL_RESET);
      // mode 00 with run set must not count
      axW(IDX_CTRL, 8'h10);
      repeat (20) @(posedge clock);
      rdChk(IDX_COUNT, COUNT_RESET);
      complete_run();
   end
endmodule : tb_tec_timer
